// ---- pkg/scd_defines.vh ----
// constants for the servo command dispatcher
`ifndef SCD_DEFINES_VH
`define SCD_DEFINES_VH
`define SCD_PROG_CODE_MIN 8'h40
`define SCD_CODE_STOP 8'h03
`define SCD_CODE_VEL_IMM 8'h0f
`define SCD_ACK_NONE 2'h0
`define SCD_ACK_OK 2'h1
`define SCD_ACK_BUSY 2'h2
`define SCD_THR_1 2'h1
`define SCD_THR_2 2'h2
`define SCD_THR_BOTH 2'h3
`define SCD_PTYPE_U16 2'h0
`define SCD_PTYPE_S16 2'h1
`define SCD_PTYPE_U32 2'h2
`define SCD_PTYPE_S32 2'h3
`endif

// ---- rtl/scd_dispatcher.v ----
// servo command admission, program buffer and dispatch
//
// Contract
// - the full 8-bit command code range 0 to 255 is decoded.
// - codes below 64 run only from the serial link, except one read as the first stored entry by load with run, and are never stored in a program.
// - codes of 64 and above are accepted live and as stored program entries.
// - a code of 64 or above arriving while a command or program runs gets a busy refusal.
// - parameters are 32 or 16 bit, signed or unsigned, and are widened by declared type.
// - immediate commands skip the program buffer and execute as soon as received.
// - immediate stop and velocity change overwrite the buffer and take over motion.
// - an immediate command that conflicts with a buffer operation gets a busy refusal.
// - a live program command is written to the buffer then run, only when the buffer is idle.
// - a program command received while the motor is active is refused busy and dropped.
// - in download mode program commands are appended to the buffer without running.
// - an assembled program can be run, stored to non-volatile memory, or loaded and run.
// - a program fills the buffer from the link or non-volatile memory before it runs.
// - program commands go to thread 1, thread 2 or both by their thread attribute.
`timescale 1ns/1ps
`include "scd_defines.vh"

module scd_dispatcher #(
   parameter DEPTH = 64,
   parameter AW = 6
)(
   input wire clock_i,
   input wire srst_i,
   // received command from the link framer
   input wire cmd_valid_i,
   input wire [7:0] cmd_code_i,
   input wire [31:0] cmd_param_i,
   input wire [1:0] cmd_ptype_i,
   input wire [1:0] cmd_thread_i,
   input wire cmd_buf_conflict_i,
   input wire cmd_stop_like_i,
   // program control requests
   input wire dl_start_i,
   input wire dl_end_i,
   input wire run_i,
   input wire store_i,
   input wire load_i,
   // external state
   input wire motor_active_i,
   input wire exec_done_i,
   input wire nvm_done_i,
   input wire [7:0] nvm_rd_code_i,
   input wire [31:0] nvm_rd_param_i,
   input wire [1:0] nvm_rd_thread_i,
   // answers
   output reg [1:0] ack_o,
   output reg exec_valid_o,
   output reg [7:0] exec_code_o,
   output reg [31:0] exec_param_o,
   output reg exec_imm_o,
   output reg [1:0] exec_thread_o,
   output reg takeover_o,
   output reg nvm_wr_o,
   output reg nvm_rd_o,
   output reg [AW-1:0] nvm_addr_o,
   output reg [7:0] nvm_wr_code_o,
   output reg [31:0] nvm_wr_param_o,
   output reg [1:0] nvm_wr_thread_o,
   output reg busy_o,
   output reg download_o
);

////////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 3'h0;
localparam ST_DL = 3'h1;
localparam ST_RUN = 3'h2;
localparam ST_WAIT = 3'h3;
localparam ST_STORE = 3'h4;
localparam ST_LOAD = 3'h5;

// widen a parameter by its declared width and signedness
function [31:0] widen;
   input [31:0] p;
   input [1:0] t;
   begin
      case (t)
         `SCD_PTYPE_U16: widen = {16'h0000, p[15:0]};
         `SCD_PTYPE_S16: widen = {{16{p[15]}}, p[15:0]};
         default: widen = p;
      endcase
   end
endfunction

reg [7:0] code_mem [0:DEPTH-1];
reg [31:0] parm_mem [0:DEPTH-1];
reg [1:0] thr_mem [0:DEPTH-1];

reg [2:0] st_q;
reg [AW-1:0] len_q;
reg [AW-1:0] ptr_q;
reg live_q;
reg load_run_q;
reg wr_pend_q;
wire prog_code = (cmd_code_i >= `SCD_PROG_CODE_MIN);
wire [31:0] wparm = widen(cmd_param_i, cmd_ptype_i);
wire buf_op = (st_q == ST_STORE) || (st_q == ST_LOAD);
wire running = (st_q == ST_RUN) || (st_q == ST_WAIT);
wire [AW-1:0] last = len_q - {{(AW-1){1'b0}}, 1'b1};

////////////////////////////////////////////////////////////////////////////////
always @(posedge clock_i)
begin
   if (srst_i)
   begin
      st_q <= ST_IDLE;
      len_q <= {AW{1'b0}};
      ptr_q <= {AW{1'b0}};
      live_q <= 1'b0;
      load_run_q <= 1'b0;
      wr_pend_q <= 1'b0;
      ack_o <= `SCD_ACK_NONE;
      exec_valid_o <= 1'b0;
      exec_code_o <= 8'h00;
      exec_param_o <= 32'h00000000;
      exec_imm_o <= 1'b0;
      exec_thread_o <= 2'h0;
      takeover_o <= 1'b0;
      nvm_wr_o <= 1'b0;
      nvm_rd_o <= 1'b0;
      nvm_addr_o <= {AW{1'b0}};
      nvm_wr_code_o <= 8'h00;
      nvm_wr_param_o <= 32'h00000000;
      nvm_wr_thread_o <= 2'h0;
      busy_o <= 1'b0;
      download_o <= 1'b0;
   end
   else
   begin
      ack_o <= `SCD_ACK_NONE;
      exec_valid_o <= 1'b0;
      takeover_o <= 1'b0;
      nvm_wr_o <= 1'b0;
      nvm_rd_o <= 1'b0;
      // done pulses must not be lost to a command in the same cycle, so the
      // machine steps on; only idle and run hold for one cycle instead
      if (!cmd_valid_i || (st_q != ST_IDLE && st_q != ST_RUN))
      begin
         case (st_q)
            ST_IDLE:
            begin
               if (dl_start_i)
               begin
                  len_q <= {AW{1'b0}};
                  st_q <= ST_DL;
                  download_o <= 1'b1;
               end
               // load with run means load and run, so load is looked at before run
               else if (load_i)
               begin
                  ptr_q <= {AW{1'b0}};
                  len_q <= {AW{1'b0}};
                  load_run_q <= run_i;
                  nvm_rd_o <= 1'b1;
                  nvm_addr_o <= {AW{1'b0}};
                  st_q <= ST_LOAD;
               end
               else if (run_i && len_q != {AW{1'b0}})
               begin
                  ptr_q <= {AW{1'b0}};
                  live_q <= 1'b0;
                  st_q <= ST_RUN;
               end
               else if (store_i && len_q != {AW{1'b0}})
               begin
                  ptr_q <= {AW{1'b0}};
                  wr_pend_q <= 1'b0;
                  st_q <= ST_STORE;
               end
            end
            ST_DL:
            begin
               if (dl_end_i)
               begin
                  st_q <= ST_IDLE;
                  download_o <= 1'b0;
               end
            end
            ST_RUN:
            begin
               exec_valid_o <= 1'b1;
               exec_imm_o <= 1'b0;
               exec_code_o <= code_mem[ptr_q];
               exec_param_o <= parm_mem[ptr_q];
               exec_thread_o <= thr_mem[ptr_q];
               st_q <= ST_WAIT;
            end
            ST_WAIT:
            begin
               if (exec_done_i)
               begin
                  if (ptr_q == last)
                  begin
                     st_q <= ST_IDLE;
                     // a live command leaves no program behind
                     if (live_q)
                        len_q <= {AW{1'b0}};
                  end
                  else
                  begin
                     ptr_q <= ptr_q + 1'b1;
                     st_q <= ST_RUN;
                  end
               end
            end
            ST_STORE:
            begin
               // one write per entry; a repeated strobe would restart the store
               if (!wr_pend_q)
               begin
                  wr_pend_q <= 1'b1;
                  nvm_wr_o <= 1'b1;
                  nvm_addr_o <= ptr_q;
                  nvm_wr_code_o <= code_mem[ptr_q];
                  nvm_wr_param_o <= parm_mem[ptr_q];
                  nvm_wr_thread_o <= thr_mem[ptr_q];
               end
               else if (nvm_done_i)
               begin
                  wr_pend_q <= 1'b0;
                  if (ptr_q == last)
                     st_q <= ST_IDLE;
                  else
                     ptr_q <= ptr_q + 1'b1;
               end
            end
            ST_LOAD:
            begin
               if (nvm_done_i)
               begin
                  code_mem[ptr_q] <= nvm_rd_code_i;
                  parm_mem[ptr_q] <= nvm_rd_param_i;
                  thr_mem[ptr_q] <= nvm_rd_thread_i;
                  len_q <= ptr_q + 1'b1;
                  // a code below 64 marks the end of the stored program
                  if (nvm_rd_code_i < `SCD_PROG_CODE_MIN || ptr_q == DEPTH[AW-1:0] - 1'b1)
                  begin
                     if (nvm_rd_code_i < `SCD_PROG_CODE_MIN)
                        len_q <= ptr_q;
                     ptr_q <= {AW{1'b0}};
                     live_q <= 1'b0;
                     st_q <= load_run_q ? ST_RUN : ST_IDLE;
                  end
                  else
                  begin
                     ptr_q <= ptr_q + 1'b1;
                     nvm_rd_o <= 1'b1;
                     nvm_addr_o <= ptr_q + 1'b1;
                  end
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
      // link commands come last, so a takeover overrides any program step above
      if (cmd_valid_i && !prog_code)
      begin
         if (cmd_buf_conflict_i && buf_op)
            ack_o <= `SCD_ACK_BUSY;
         else
         begin
            // never written to the buffer, straight out
            ack_o <= `SCD_ACK_OK;
            exec_valid_o <= 1'b1;
            exec_imm_o <= 1'b1;
            exec_code_o <= cmd_code_i;
            exec_param_o <= wparm;
            exec_thread_o <= `SCD_THR_1;
            if (cmd_stop_like_i)
            begin
               takeover_o <= 1'b1;
               len_q <= {AW{1'b0}};
               st_q <= ST_IDLE;
               download_o <= 1'b0;
            end
         end
      end
      else if (cmd_valid_i)
      begin
         if (st_q == ST_DL && !motor_active_i)
         begin
            if (len_q == DEPTH[AW-1:0] - 1'b1)
               ack_o <= `SCD_ACK_BUSY;
            else
            begin
               code_mem[len_q] <= cmd_code_i;
               parm_mem[len_q] <= wparm;
               thr_mem[len_q] <= cmd_thread_i;
               len_q <= len_q + 1'b1;
               ack_o <= `SCD_ACK_OK;
            end
         end
         else if (st_q != ST_IDLE || motor_active_i)
            ack_o <= `SCD_ACK_BUSY;
         else
         begin
            // single-entry buffer then run from it
            code_mem[0] <= cmd_code_i;
            parm_mem[0] <= wparm;
            thr_mem[0] <= cmd_thread_i;
            len_q <= {{(AW-1){1'b0}}, 1'b1};
            ptr_q <= {AW{1'b0}};
            live_q <= 1'b1;
            st_q <= ST_RUN;
            ack_o <= `SCD_ACK_OK;
         end
      end
      busy_o <= running || buf_op;
   end
end

endmodule

// ---- testbench/scd_dispatcher_asserts.sv ----
// checker for the command dispatcher ports
`timescale 1ns/1ps
module scd_dispatcher_asserts(
   input wire clock_i,
   input wire srst_i,
   input wire cmd_valid_i,
   input wire [7:0] cmd_code_i,
   input wire cmd_buf_conflict_i,
   input wire cmd_stop_like_i,
   input wire motor_active_i,
   input wire exec_done_i,
   input wire nvm_done_i,
   input wire run_i,
   input wire store_i,
   input wire load_i,
   input wire [1:0] ack_o,
   input wire exec_valid_o,
   input wire [7:0] exec_code_o,
   input wire exec_imm_o,
   input wire [1:0] exec_thread_o,
   input wire takeover_o,
   input wire nvm_wr_o,
   input wire [7:0] nvm_wr_code_o,
   input wire busy_o,
   input wire download_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (srst_i);
   wire prog_cmd = cmd_valid_i && cmd_code_i >= 8'h40;
   wire imm_cmd = cmd_valid_i && cmd_code_i < 8'h40;
   // busy_o trails the state by one cycle, so the cycle after a finish is left out
   busy_refuse_a: assert property (prog_cmd && busy_o && !$past(exec_done_i) &&
      !$past(nvm_done_i) && !takeover_o |=> ack_o == 2'h2)
      else $error("program code taken while busy");
   motor_refuse_a: assert property (prog_cmd && motor_active_i |=> ack_o == 2'h2)
      else $error("program code taken while motor active");
   imm_exec_a: assert property (imm_cmd && !cmd_buf_conflict_i |=>
      ack_o == 2'h1 && exec_valid_o && exec_imm_o && exec_code_o == $past(cmd_code_i))
      else $error("immediate code not run at once");
   takeover_on_a: assert property (imm_cmd && !cmd_buf_conflict_i && cmd_stop_like_i |=> takeover_o)
      else $error("no takeover");
   takeover_cause_a: assert property (takeover_o |-> $past(cmd_valid_i && cmd_stop_like_i))
      else $error("takeover without cause");
   live_run_a: assert property (prog_cmd && !busy_o && !download_o && !motor_active_i &&
      ack_o == 2'h0 && !$past(run_i || store_i || load_i) |=>
      ack_o == 2'h1 ##1 exec_valid_o && exec_code_o == $past(cmd_code_i, 2))
      else $error("live program code not run");
   prog_code_a: assert property (exec_valid_o && !exec_imm_o |->
      exec_code_o >= 8'h40 && exec_thread_o != 2'h0)
      else $error("bad program entry run");
   store_code_a: assert property (nvm_wr_o |-> nvm_wr_code_o >= 8'h40)
      else $error("immediate code stored");
   dl_hold_a: assert property (prog_cmd && download_o && ack_o == 2'h0 |=> !exec_valid_o [*2])
      else $error("download entry run");
   cover property (prog_cmd && busy_o);
   cover property (takeover_o);
   cover property (nvm_wr_o);
   cover property (prog_cmd && download_o);
endmodule
bind scd_dispatcher scd_dispatcher_asserts u_chk(.clock_i, .srst_i, .cmd_valid_i, .cmd_code_i,
   .cmd_buf_conflict_i, .cmd_stop_like_i, .motor_active_i, .exec_done_i, .ack_o, .exec_valid_o,
   .exec_code_o, .exec_imm_o, .exec_thread_o, .takeover_o, .nvm_wr_o, .nvm_wr_code_o, .busy_o,
   .download_o, .nvm_done_i, .run_i, .store_i, .load_i);

// ---- testbench/scd_nvm_model.sv ----
// non-volatile program store answering the dispatcher
`timescale 1ns/1ps
module scd_nvm_model #(
   parameter LAT = 3
)(
   input wire clock_i,
   input wire wr_i,
   input wire rd_i,
   input wire [5:0] addr_i,
   input wire [41:0] wdata_i,
   output logic done_o = 1'b0,
   output logic [41:0] rdata_o = 42'h0
);
   logic [41:0] mem [0:63];
   logic [5:0] addr_q = 6'h0;
   logic [7:0] cnt_q = 8'h0;
   initial for (int i = 0; i < 64; i++) mem[i] = 42'h0;
   // read data toggles outside done so a stale sample never looks right
   always @(posedge clock_i)
   begin
      done_o <= cnt_q == 8'h1;
      rdata_o <= (cnt_q == 8'h1) ? mem[addr_q] : ~rdata_o;
      if (wr_i)
         mem[addr_i] <= wdata_i;
      if (wr_i || rd_i)
         addr_q <= addr_i;
      cnt_q <= (wr_i || rd_i) ? LAT[7:0] : ((cnt_q != 8'h0) ? cnt_q - 8'h1 : 8'h0);
   end
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for the command dispatcher
`timescale 1ns/1ps
module tb;
   logic clock_i = 0, srst_i = 1, cmd_valid_i = 0, cmd_conf = 0, cmd_stop = 0, motor = 0;
   logic done = 0;
   logic [2:0] dly = 3'h0;
   logic [7:0] code = 8'h00;
   logic [31:0] param = 32'h0;
   logic [1:0] ptype = 2'h0, thr = 2'h0;
   logic [4:0] ctl = 5'h0;
   int mismatches = 0, comparisons = 0;
   wire [1:0] ack_o, exec_thread_o;
   wire exec_valid_o, exec_imm_o, takeover_o, nvm_wr_o, nvm_rd_o, nvm_done, busy_o, download_o;
   wire [7:0] exec_code_o;
   wire [31:0] exec_param_o;
   wire [5:0] nvm_addr_o;
   wire [41:0] wdata, rdata;
   always #5 clock_i = ~clock_i;
   // executor answers a few cycles after each program entry
   always @(posedge clock_i)
   begin
      dly <= {dly[1:0], exec_valid_o && !exec_imm_o};
      done <= #1 dly[2];
   end
   scd_dispatcher dut(.clock_i, .srst_i, .cmd_valid_i, .cmd_code_i(code), .cmd_param_i(param),
      .cmd_ptype_i(ptype), .cmd_thread_i(thr), .cmd_buf_conflict_i(cmd_conf),
      .cmd_stop_like_i(cmd_stop), .dl_start_i(ctl[0]), .dl_end_i(ctl[1]), .run_i(ctl[2]),
      .store_i(ctl[3]), .load_i(ctl[4]), .motor_active_i(motor), .exec_done_i(done),
      .nvm_done_i(nvm_done), .nvm_rd_code_i(rdata[41:34]), .nvm_rd_param_i(rdata[33:2]),
      .nvm_rd_thread_i(rdata[1:0]), .ack_o, .exec_valid_o, .exec_code_o, .exec_param_o,
      .exec_imm_o, .exec_thread_o, .takeover_o, .nvm_wr_o, .nvm_rd_o, .nvm_addr_o,
      .nvm_wr_code_o(wdata[41:34]), .nvm_wr_param_o(wdata[33:2]),
      .nvm_wr_thread_o(wdata[1:0]), .busy_o, .download_o);
   scd_nvm_model nvm(.clock_i, .wr_i(nvm_wr_o), .rd_i(nvm_rd_o), .addr_i(nvm_addr_o),
      .wdata_i(wdata), .done_o(nvm_done), .rdata_o(rdata));
   //////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [41:0] seen, input logic [41:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one command at a time; caller reads the answer as soon as this returns
   task automatic send(input logic [7:0] c, input logic [1:0] pt, input logic [1:0] th);
      @(posedge clock_i) #1;
      cmd_valid_i = 1;
      code = c;
      ptype = pt;
      thr = th;
      @(posedge clock_i) #1;
      cmd_valid_i = 0;
   endtask
   task automatic go(input logic [4:0] v);
      @(posedge clock_i) #1;
      ctl = v;
      @(posedge clock_i) #1;
      ctl = 5'h0;
   endtask
   task automatic wait_exec;
      for (int i = 0; i < 60 && exec_valid_o !== 1'b1; i++) @(posedge clock_i) #1;
      chk("exec wait", exec_valid_o, 1'b1);
   endtask
   task automatic wait_idle;
      for (int i = 0; i < 300 && busy_o !== 1'b0; i++) @(posedge clock_i) #1;
      chk("idle wait", busy_o, 1'b0);
   endtask
   //////////////////////////////////////////////////////////////////////
   task automatic t_imm;
      cmd_stop = 1;
      send(8'h3f, 2'h0, 2'h0);
      chk("imm ack", ack_o, 2'h1);
      chk("imm exec", {exec_valid_o, exec_imm_o, takeover_o}, 3'h7);
      chk("imm code", exec_code_o, 8'h3f);
      cmd_stop = 0;
      $display("end imm");
   endtask
   task automatic t_live;
      logic [7:0] codes [4] = '{8'h40, 8'h7f, 8'hc0, 8'hff};
      logic [1:0] thrs [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
      logic [31:0] wide [4] = '{32'h00008001, 32'hffff8001, 32'h12348001, 32'h12348001};
      param = 32'h12348001;
      for (int i = 0; i < 4; i++)
      begin
         send(codes[i], 2'(i), thrs[i]);
         chk("live ack", ack_o, 2'h1);
         wait_exec;
         chk("live code", exec_code_o, codes[i]);
         chk("live param", exec_param_o, wide[i]);
         chk("live thread", exec_thread_o, thrs[i]);
         wait_idle;
      end
      $display("end live");
   endtask
   task automatic t_busy;
      send(8'h41, 2'h0, 2'h1);
      wait_exec;
      send(8'h42, 2'h0, 2'h1);
      chk("busy ack", ack_o, 2'h2);
      wait_idle;
      motor = 1;
      send(8'h80, 2'h0, 2'h1);
      chk("motor ack", ack_o, 2'h2);
      motor = 0;
      repeat (3) @(posedge clock_i) #1;
      chk("motor drop", busy_o, 1'h0);
      $display("end busy");
   endtask
   task automatic t_prog;
      go(5'h01);
      chk("dl flag", download_o, 1'h1);
      send(8'h50, 2'h0, 2'h1);
      chk("dl ack", ack_o, 2'h1);
      send(8'h60, 2'h0, 2'h3);
      go(5'h02);
      chk("dl idle", busy_o, 1'h0);
      chk("dl end", download_o, 1'h0);
      go(5'h08);
      cmd_conf = 1;
      send(8'h10, 2'h0, 2'h0);
      chk("conflict ack", ack_o, 2'h2);
      cmd_conf = 0;
      wait_idle;
      chk("stored", nvm.mem[1][41:34], 8'h60);
      // a stop empties the buffer, so the run below can only come from the store
      cmd_stop = 1;
      send(8'h03, 2'h0, 2'h0);
      chk("stop takeover", takeover_o, 1'h1);
      cmd_stop = 0;
      go(5'h04);
      @(posedge clock_i) #1;
      chk("stop cleared", busy_o, 1'h0);
      go(5'h14);
      wait_exec;
      chk("run first", {exec_code_o, exec_thread_o}, {8'h50, 2'h1});
      @(posedge clock_i) #1;
      wait_exec;
      chk("run second", {exec_code_o, exec_thread_o}, {8'h60, 2'h3});
      wait_idle;
      $display("end prog");
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge clock_i);
      #1 srst_i = 0;
      t_imm;
      t_live;
      t_busy;
      t_prog;
      test_done;
   end
   initial
   begin
      #100000;
      mismatches++;
      test_done;
   end
endmodule
